// File: rtl/oiro_top.sv
// Optical serial port output stage: AXI4-Lite registers, FIFO, transmitter, carrier and pin logic
//
// Operation
// - Drive transmit pin only when select is 00
// - Invert transmit output and receive input independently
// - Carrier of 38 kHz modulates transmit when enabled
// - No carrier while in battery fallback mode
// - Duty field selects 50, 25, 12.5, 6.25 percent
// - Duty percentage is the low part of period
// - Receive pin read as plain level, no demodulation
// - Fallback mode when power fails with battery present
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Transmit FIFO with valid and ready on both sides
module oiro_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	// Whole state of the FIFO
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
		logic [AW:0] wr; // Write pointer with wrap bit
		logic [AW:0] rd; // Read pointer with wrap bit
	} oiro_fifo_st_t;

	oiro_fifo_st_t st_r;
	oiro_fifo_st_t st_nxt;
	logic empty;
	logic full;

	// Full when pointers differ only in the wrap bit
	assign empty = st_r.wr == st_r.rd;
	assign full = (st_r.wr[AW] != st_r.rd[AW]) && (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = st_r.mem[st_r.rd[AW-1:0]];

	// Next state: push and pop
	always_comb begin
		st_nxt = st_r;
		if (i_in_valid && !full) begin
			st_nxt.mem[st_r.wr[AW-1:0]] = i_in_data;
			st_nxt.wr = st_r.wr + 1'b1;
		end
		if (i_out_ready && !empty) begin
			st_nxt.rd = st_r.rd + 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r.wr <= '0;
			st_r.rd <= '0;
			st_r.mem <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top of the output stage
module oiro_top #(
	parameter int P_CARRIER_CYC = oiro_pkg::CARRIER_CYC // Carrier period in cycles
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire oiro_pkg::oiro_axi_req_t i_axi,
	output oiro_pkg::oiro_axi_rsp_t o_axi,
	input wire logic i_ir_rx_in,
	input wire logic i_sys_power_ok,
	input wire logic i_battery_ok,
	output logic o_ir_tx_out,
	output logic o_ir_tx_oe,
	output logic o_ir_rx_level,
	output logic o_fallback_mode
);
	import oiro_pkg::*;

	// Whole state of the block
	typedef struct packed {
		oiro_ctrl_t ctrl; // Control register
		logic [15:0] baud; // Bit time divisor minus one
		logic [SY_N-1:0] sy1; // Synchroniser first stage
		logic [SY_N-1:0] sy2; // Synchroniser second stage
		logic [SY_N-1:0] sy3; // Synchroniser third stage
		logic [SY_N-1:0] stab; // Agreed input levels
		logic fallback; // Battery fallback mode
		logic rx_level; // Received level after inversion
		logic aw_got; // Write address held
		logic w_got; // Write data held
		logic [3:0] waddr; // Held write address
		logic [31:0] wdata; // Held write data
		logic [3:0] wstrb; // Held byte strobes
		oiro_axi_rsp_t rsp; // Bus answer signals
		oiro_txst_t txst; // Transmitter state
		logic [9:0] shreg; // Frame shift register
		logic [3:0] bitcnt; // Bits left in frame
		logic [15:0] baudcnt; // Bit time counter
		logic tx_line; // Serial line before the pin stage
		logic [CAR_CNT_W-1:0] car_cnt; // Carrier phase counter
		logic pin_out; // Pin level
		logic pin_oe; // Pin enable
	} oiro_state_t;

	oiro_state_t st_r;
	oiro_state_t st_nxt;
	logic [SY_N-1:0] stab_nxt; // Agreed levels from the synchroniser
	logic fifo_in_valid; // Push into FIFO
	logic fifo_in_ready; // FIFO has room
	logic fifo_out_valid; // FIFO holds a byte
	logic [FIFO_W-1:0] fifo_out_data; // Oldest byte
	logic fifo_out_ready; // Transmitter takes a byte
	logic mod_active; // Carrier applied
	logic car_low; // Carrier in its low part
	logic [CAR_CNT_W-1:0] low_len; // Low part length in cycles
	logic wr_fire; // Write address and data both held
	logic [31:0] status_word; // Status read value

	////////////////////////////////////////////////////////////////////////////////
	// Input synchroniser: a level counts once second and third stages agree
	genvar g;
	generate
		for (g = 0; g < SY_N; g++) begin : g_sync
			assign stab_nxt[g] = (st_r.sy2[g] == st_r.sy3[g]) ? st_r.sy3[g] : st_r.stab[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Transmit FIFO
	oiro_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_in_valid(fifo_in_valid),
		.i_in_data(st_r.wdata[FIFO_W-1:0]),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(fifo_out_ready)
	);

	// Helper terms
	assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid;
	assign fifo_in_valid = wr_fire && (st_r.waddr == ADDR_TXDATA) && st_r.wstrb[0];
	assign fifo_out_ready = st_r.txst == TX_IDLE;
	assign mod_active = st_r.ctrl.car_en && !st_r.fallback;
	assign low_len = CAR_CNT_W'(P_CARRIER_CYC >> ({1'b0, st_r.ctrl.duty} + 3'h1));
	assign car_low = st_r.car_cnt < low_len;
	assign status_word = {27'h000_0000, st_r.txst == TX_SHIFT, !fifo_in_ready, !fifo_out_valid,
		st_r.rx_level, st_r.fallback};

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Synchroniser stages
		st_nxt.sy1 = {i_battery_ok, i_sys_power_ok, i_ir_rx_in};
		st_nxt.sy2 = st_r.sy1;
		st_nxt.sy3 = st_r.sy2;
		st_nxt.stab = stab_nxt;
		// Fallback when power has failed and a battery holds the chip up
		st_nxt.fallback = !st_r.stab[SY_PWR] && st_r.stab[SY_BAT];
		// Receive level is the plain pin level, optionally inverted
		st_nxt.rx_level = st_r.stab[SY_RX] ^ st_r.ctrl.rx_inv;

		// Write address and data taken in either order
		if (i_axi.awvalid && st_r.rsp.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.waddr = i_axi.awaddr[3:0];
		end
		if (i_axi.wvalid && st_r.rsp.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = i_axi.wdata;
			st_nxt.wstrb = i_axi.wstrb;
		end
		// Write response retires
		if (st_r.rsp.bvalid && i_axi.bready) begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		// Perform the write; a push into a full FIFO waits for room
		if (wr_fire && !(fifo_in_valid && !fifo_in_ready)) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = RESP_OKAY;
			case (st_r.waddr)
				ADDR_CTRL: begin
					if (st_r.wstrb[0]) begin
						st_nxt.ctrl = st_r.wdata[CTRL_DUTY_LSB+1:CTRL_SEL_LSB];
					end
				end
				ADDR_BAUD: begin
					if (st_r.wstrb[0]) begin
						st_nxt.baud[7:0] = st_r.wdata[7:0];
					end
					if (st_r.wstrb[1]) begin
						st_nxt.baud[15:8] = st_r.wdata[15:8];
					end
				end
				ADDR_TXDATA, ADDR_STATUS: begin
					// Push handled by the FIFO; status ignores writes
					st_nxt.rsp.bresp = RESP_OKAY;
				end
				default: begin
					st_nxt.rsp.bresp = RESP_SLVERR;
				end
			endcase
		end
		st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
		st_nxt.rsp.wready = !st_nxt.w_got && !st_nxt.rsp.bvalid;

		// Read path: one cycle from address to data
		if (st_r.rsp.rvalid && i_axi.rready) begin
			st_nxt.rsp.rvalid = 1'b0;
		end
		if (i_axi.arvalid && st_r.rsp.arready) begin
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rresp = RESP_OKAY;
			case (i_axi.araddr[3:0])
				ADDR_CTRL: begin
					st_nxt.rsp.rdata = {25'h000_0000, st_r.ctrl};
				end
				ADDR_STATUS: begin
					st_nxt.rsp.rdata = status_word;
				end
				ADDR_BAUD: begin
					st_nxt.rsp.rdata = {16'h0000, st_r.baud};
				end
				ADDR_TXDATA: begin
					st_nxt.rsp.rdata = 32'h0000_0000;
				end
				default: begin
					st_nxt.rsp.rdata = 32'h0000_0000;
					st_nxt.rsp.rresp = RESP_SLVERR;
				end
			endcase
		end
		st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

		// Serial transmitter, start bit low, stop bit high
		case (st_r.txst)
			TX_IDLE: begin
				st_nxt.tx_line = 1'b1;
				if (fifo_out_valid) begin
					st_nxt.shreg = {1'b1, fifo_out_data, 1'b0};
					st_nxt.bitcnt = 4'h9;
					st_nxt.baudcnt = st_r.baud;
					st_nxt.txst = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				st_nxt.tx_line = st_r.shreg[0];
				if (st_r.baudcnt == 16'h0000) begin
					st_nxt.baudcnt = st_r.baud;
					st_nxt.shreg = {1'b1, st_r.shreg[9:1]};
					if (st_r.bitcnt == 4'h0) begin
						st_nxt.txst = TX_IDLE;
					end else begin
						st_nxt.bitcnt = st_r.bitcnt - 4'h1;
					end
				end else begin
					st_nxt.baudcnt = st_r.baudcnt - 16'h0001;
				end
			end
			default: begin
				st_nxt.txst = TX_IDLE;
			end
		endcase

		// Free-running carrier phase
		if (st_r.car_cnt >= CAR_CNT_W'(P_CARRIER_CYC - 1)) begin
			st_nxt.car_cnt = '0;
		end else begin
			st_nxt.car_cnt = st_r.car_cnt + 1'b1;
		end

		// Pin stage: carrier only in active (low) bits, then polarity
		if (mod_active && !st_r.tx_line) begin
			st_nxt.pin_out = !car_low ^ st_r.ctrl.tx_inv;
		end else begin
			st_nxt.pin_out = st_r.tx_line ^ st_r.ctrl.tx_inv;
		end
		st_nxt.pin_oe = st_r.ctrl.pin_sel == SEL_SERIAL;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r <= '0;
			st_r.ctrl.pin_sel <= SEL_RST;
			st_r.baud <= BAUD_RST;
			st_r.txst <= TX_IDLE;
			st_r.tx_line <= 1'b1;
			st_r.pin_out <= 1'b1;
			st_r.rsp.awready <= 1'b1;
			st_r.rsp.wready <= 1'b1;
			st_r.rsp.arready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_axi = st_r.rsp;
	assign o_ir_tx_out = st_r.pin_out;
	assign o_ir_tx_oe = st_r.pin_oe;
	assign o_ir_rx_level = st_r.rx_level;
	assign o_fallback_mode = st_r.fallback;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_ar_take;
		i_axi.arvalid && o_axi.arready;
	endsequence
	sequence s_rd_answer;
		o_axi.rvalid ##0 !o_axi.arready;
	endsequence

	a_pin_enable_select: assert property (
		##1 o_ir_tx_oe == ($past(st_r.ctrl.pin_sel) == SEL_SERIAL)
	) else $error("pin enable does not follow pin select");

	a_tx_plain_invert: assert property (
		!mod_active |=> o_ir_tx_out == ($past(st_r.tx_line) ^ $past(st_r.ctrl.tx_inv))
	) else $error("unmodulated output not line xor invert");

	a_rx_level_invert: assert property (
		##1 o_ir_rx_level == ($past(st_r.stab[SY_RX]) ^ $past(st_r.ctrl.rx_inv))
	) else $error("receive level not pin xor invert");

	a_carrier_wrap: assert property (
		st_r.car_cnt == CAR_CNT_W'(P_CARRIER_CYC - 1) |=> st_r.car_cnt == '0 ##1 st_r.car_cnt == 1
	) else $error("carrier period wrong");

	a_fallback_no_carrier: assert property (
		st_r.fallback |=> o_ir_tx_out == ($past(st_r.tx_line) ^ $past(st_r.ctrl.tx_inv))
	) else $error("carrier seen in fallback mode");

	a_duty_low_part: assert property (
		mod_active && !st_r.tx_line && st_r.car_cnt < CAR_CNT_W'(P_CARRIER_CYC / (2 << st_r.ctrl.duty))
		|=> o_ir_tx_out == $past(st_r.ctrl.tx_inv)
	) else $error("carrier not low in duty part");

	a_duty_high_part: assert property (
		mod_active && !st_r.tx_line && st_r.car_cnt >= CAR_CNT_W'(P_CARRIER_CYC / (2 << st_r.ctrl.duty))
		|=> o_ir_tx_out == !$past(st_r.ctrl.tx_inv)
	) else $error("carrier not high outside duty part");

	a_fallback_cause: assert property (
		##1 o_fallback_mode == (!$past(st_r.stab[SY_PWR]) && $past(st_r.stab[SY_BAT]))
	) else $error("fallback mode not from power and battery");

	a_idle_no_carrier: assert property (
		st_r.tx_line |=> o_ir_tx_out == !$past(st_r.ctrl.tx_inv)
	) else $error("idle level disturbed by carrier");

	a_read_answer: assert property (
		s_ar_take |=> s_rd_answer
	) else $error("read not answered next cycle");

endmodule
`default_nettype wire

// File: rtl/oiro_pkg.sv
// Package: constants, register map and bus types for the optical serial port output stage
package oiro_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and carrier timing
	localparam int CLK_HZ = 250_000_000; // System clock rate
	localparam int CARRIER_HZ = 38_000; // Carrier frequency
	localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ; // Carrier period in clock cycles
	localparam int CAR_CNT_W = 13; // Width of the carrier phase counter

	////////////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses, low nibble decoded)
	localparam logic [3:0] ADDR_CTRL = 4'h0; // Pin and carrier control
	localparam logic [3:0] ADDR_STATUS = 4'h4; // Read-only status
	localparam logic [3:0] ADDR_TXDATA = 4'h8; // Transmit byte, pushed into the FIFO
	localparam logic [3:0] ADDR_BAUD = 4'hC; // Bit time divisor minus one

	// Control register fields
	localparam int CTRL_SEL_LSB = 0; // ir_tx_pin_select[1:0]
	localparam int CTRL_TXINV_BIT = 2; // ir_tx_invert
	localparam int CTRL_RXINV_BIT = 3; // ir_rx_invert
	localparam int CTRL_CAREN_BIT = 4; // ir_carrier_enable
	localparam int CTRL_DUTY_LSB = 5; // ir_carrier_duty[1:0]

	// Status register fields
	localparam int STAT_FALLBACK_BIT = 0; // Battery-backed fallback mode
	localparam int STAT_RXLVL_BIT = 1; // Received level after inversion
	localparam int STAT_EMPTY_BIT = 2; // FIFO empty
	localparam int STAT_FULL_BIT = 3; // FIFO full
	localparam int STAT_BUSY_BIT = 4; // Transmitter busy

	// Pin select, reset values and response codes
	localparam logic [1:0] SEL_SERIAL = 2'h0; // Pin select value that gives the pin to the serial port
	localparam logic [1:0] SEL_RST = 2'h1; // Pin left to its alternate function after reset
	localparam logic [15:0] BAUD_RST = 16'h0823; // Bit time divisor after reset
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error

	// FIFO shape and synchroniser slots
	localparam int FIFO_W = 8; // Data width
	localparam int FIFO_D = 16; // Depth in words
	localparam int SY_RX = 0; // Receive pin
	localparam int SY_PWR = 1; // System power good
	localparam int SY_BAT = 2; // Battery present
	localparam int SY_N = 3; // Number of synchronised inputs

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic {TX_IDLE, TX_SHIFT} oiro_txst_t; // Transmitter states

	typedef struct packed {
		logic [1:0] duty; // ir_carrier_duty
		logic car_en; // ir_carrier_enable
		logic rx_inv; // ir_rx_invert
		logic tx_inv; // ir_tx_invert
		logic [1:0] pin_sel; // ir_tx_pin_select
	} oiro_ctrl_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} oiro_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} oiro_axi_rsp_t;

endpackage

// File: testbench/oiro_ir_partner.sv
// Partner model: emitter and phototransistor on the far side of the optical pins
`timescale 1ns/1ps
`default_nettype none

module oiro_ir_partner (
	input wire logic i_sys_clk,
	input wire logic i_tx_pin,
	input wire logic i_tx_oe,
	input wire logic i_clr,
	input wire logic i_light,
	output logic o_rx_pin,
	output logic [15:0] o_max_low,
	output logic [15:0] o_period
);
	logic seen; // Level the emitter acts on
	logic [15:0] run; // Length of the current low run
	logic [15:0] since; // Cycles since the last falling edge

	// Emitter stays dark while the pin is not driven, as a pulled-up line would
	assign seen = i_tx_oe ? i_tx_pin : 1'b1;
	// Phototransistor passes the light level straight through, no demodulation
	assign o_rx_pin = i_light;

	////////////////////////////////////////////////////////////////////////////////
	// Measure the longest low run and the spacing of falling edges
	always @(posedge i_sys_clk) begin
		if (i_clr) begin
			run <= 16'h0000;
			since <= 16'h0000;
			o_max_low <= 16'h0000;
			o_period <= 16'h0000;
		end else begin
			run <= seen ? 16'h0000 : run + 16'h0001;
			since <= since + 16'h0001;
			// Low cycle: grow the longest run
			if (!seen && run + 16'h0001 > o_max_low) begin
				o_max_low <= run + 16'h0001;
			end
			// Falling edge: record the spacing from the previous one
			if (!seen && run == 16'h0000) begin
				o_period <= since;
				since <= 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/optical_uart_ir_output_stage_test.sv
// Testbench: register access, pin control, carrier and fallback of the optical output stage
`timescale 1ns/1ps
`default_nettype none

module optical_uart_ir_output_stage_test;
	import oiro_pkg::*;
	localparam int CYC = 32; // Shortened carrier period
	logic sys_clk = 1'b0; // System clock, 4 ns
	logic rst; // Synchronous reset
	oiro_axi_req_t axi; // Register bus requests
	oiro_axi_rsp_t rsp; // Register bus answers
	logic light, pwr_ok, bat_ok, clr; // Far side and supply inputs
	logic rx_pin, tx_out, tx_oe, rx_lvl, fb; // Pin level signals
	logic [15:0] max_low, period; // Partner measurements
	logic [31:0] d; // Read data
	logic [1:0] r; // Response code
	int err_count = 0; // Mismatches
	int compares = 0; // Comparisons made

	always #2 sys_clk = ~sys_clk;

	oiro_top #(.P_CARRIER_CYC(CYC)) dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_axi(axi), .o_axi(rsp),
		.i_ir_rx_in(rx_pin), .i_sys_power_ok(pwr_ok), .i_battery_ok(bat_ok), .o_ir_tx_out(tx_out),
		.o_ir_tx_oe(tx_oe), .o_ir_rx_level(rx_lvl), .o_fallback_mode(fb));
	oiro_ir_partner part_u (.i_sys_clk(sys_clk), .i_tx_pin(tx_out), .i_tx_oe(tx_oe), .i_clr(clr),
		.i_light(light), .o_rx_pin(rx_pin), .o_max_low(max_low), .o_period(period));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Control word from its fields
	function automatic logic [31:0] ctl(logic [1:0] du, logic ce, logic ri, logic ti, logic [1:0] sel);
		return {25'h000_0000, du, ce, ri, ti, sel};
	endfunction

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] wr_r);
		axi.awvalid <= 1'b1;
		axi.awaddr <= {28'h000_0000, a};
		axi.wvalid <= 1'b1;
		axi.wdata <= wd;
		do begin
			@(posedge sys_clk);
			if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
			if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		wr_r = rsp.bresp;
	endtask

	// Read: address held until taken, data taken with rvalid
	task automatic rd(input logic [3:0] a, output logic [31:0] rd_d, output logic [1:0] rd_r);
		axi.arvalid <= 1'b1;
		axi.araddr <= {28'h000_0000, a};
		do begin
			@(posedge sys_clk);
			if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rd_d = rsp.rdata;
		rd_r = rsp.rresp;
	endtask

	// Poll until the FIFO is empty and the transmitter idle
	task automatic wait_idle;
		logic [31:0] sd;
		logic [1:0] sr;
		do rd(ADDR_STATUS, sd, sr); while (sd[4:2] !== 3'b001);
	endtask

	// Send an all-zero byte with the partner's measurements cleared first
	task automatic send0;
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		wr(ADDR_TXDATA, 32'h0000_0000, r);
		wait_idle();
	endtask

	// Print counts and verdict, then stop
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		axi <= oiro_axi_req_t'{bready: 1'b1, rready: 1'b1, wstrb: 4'hF, default: '0};
		rst <= 1'b1;
		light <= 1'b0;
		pwr_ok <= 1'b1;
		bat_ok <= 1'b1;
		clr <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Reset state: pin left to its alternate function
		rd(ADDR_CTRL, d, r);
		chk(d, 32'h0000_0001);
		chk(tx_oe, 32'h0000_0000);
		rd(ADDR_BAUD, d, r);
		chk(d, {16'h0000, BAUD_RST});
		rd(ADDR_STATUS, d, r);
		chk(d[4:0], 32'h0000_0004);
		rd(4'h2, d, r);
		chk({d, r}, {32'h0000_0000, RESP_SLVERR});
		wr(4'h6, 32'h0000_0000, r);
		chk(r, RESP_SLVERR);
		// Status ignores writes, transmit data reads as zero
		wr(ADDR_STATUS, 32'hFFFF_FFFF, r);
		chk(r, RESP_OKAY);
		rd(ADDR_TXDATA, d, r);
		chk({d, r}, {32'h0000_0000, RESP_OKAY});
		// Pin drive only for select value 00
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b0, s[1:0]), r);
			repeat (2) @(posedge sys_clk);
			chk(tx_oe, s == 0);
		end
		// Transmit inversion on the idle line
		wr(ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b1, SEL_SERIAL), r);
		repeat (2) @(posedge sys_clk);
		chk(tx_out, 32'h0000_0000);
		// Receive inversion over both light levels
		for (int i = 0; i < 4; i++) begin
			light <= i[0];
			wr(ADDR_CTRL, ctl(2'h0, 1'b0, i[1], 1'b0, SEL_SERIAL), r);
			repeat (8) @(posedge sys_clk);
			chk(rx_lvl, i[0] ^ i[1]);
			rd(ADDR_STATUS, d, r);
			chk(d[1], i[0] ^ i[1]);
		end
		// Fill the FIFO while the transmitter is on its first byte
		wr(ADDR_BAUD, 32'h0000_0013, r);
		for (int i = 0; i < 17; i++) begin
			wr(ADDR_TXDATA, i, r);
		end
		rd(ADDR_STATUS, d, r);
		chk(d[4:2], 32'h0000_0006);
		wait_idle();
		chk(tx_out, 32'h0000_0001);
		// Carrier at every duty setting
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CTRL, ctl(k[1:0], 1'b1, 1'b0, 1'b0, SEL_SERIAL), r);
			send0();
			chk(max_low, CYC >> (k + 1));
			chk(period, CYC);
			chk(tx_out, 32'h0000_0001);
		end
		// Battery fallback suppresses the carrier
		pwr_ok <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(fb, 32'h0000_0001);
		rd(ADDR_STATUS, d, r);
		chk(d[0], 32'h0000_0001);
		send0();
		chk(max_low, 9 * 20);
		bat_ok <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(fb, 32'h0000_0000);
		summarize();
	end
endmodule
`default_nettype wire
